/* File: fsud_pkg.sv */
// Purpose: constants and types of the full-speed device port
// Assumes: one system clock, bus-side clock sampled as a pin
// Notes: endpoint buffer layout is fixed at elaboration
// Summary of operation
// - eight endpoints; banks of 64 or 512 bytes
// - one shared 2688-byte buffer RAM for all endpoints
// - dual-bank endpoints ping-pong between CPU and bus
// - per-endpoint transfer type with limited legal choices
// - suspend and resume detected, each raises interrupt
// - external resume drives remote wake when host allowed
// - CPU moves data as 8-bit FIFO accesses
// - master clock for logic, 48 MHz for bus timing
// - switchable D+ pull-up; pull-downs while transceiver off
// - pins are USB after reset until I/O reconfigured
// - one interrupt line, peripheral number 34
package fsud_pkg;
    localparam int FSUD_NUM_EP = 8;
    localparam int FSUD_RAM_BYTES = 2688;
    localparam int FSUD_SMALL_BANK = 64;
    localparam int FSUD_LARGE_BANK = 512;
    localparam int FSUD_PERIPH_ID = 34;
    localparam int FSUD_BIT_MHZ = 12;
    localparam int FSUD_SUSPEND_US = 3000;
    localparam int FSUD_SUSPEND_TICKS = FSUD_SUSPEND_US * FSUD_BIT_MHZ;
    localparam int FSUD_RESUME_US = 2000;
    localparam int FSUD_RESUME_TICKS = FSUD_RESUME_US * FSUD_BIT_MHZ;
    localparam logic [1:0] FSUD_TICK_DIV_LAST = 2'h3;
    localparam logic [7:0] FSUD_DUAL_MASK = 8'hF6;
    localparam logic [7:0] FSUD_LARGE_MASK = 8'h30;
    localparam logic [1:0] FSUD_BUF_DEPTH = 2'h2;
    localparam logic [7:0] FSUD_BANK_RST = 8'h00;

    typedef enum logic [1:0] {
        FSUD_CONTROL = 2'h0,
        FSUD_BULK = 2'h1,
        FSUD_ISO = 2'h2,
        FSUD_INTR = 2'h3
    } fsud_type_t;

    typedef logic [FSUD_NUM_EP-1:0][11:0] fsud_base_tab_t;
    // Base of bank 0 of each endpoint; bank 1 follows directly
    localparam fsud_base_tab_t FSUD_EP_BASE = {12'hA00, 12'h980, 12'h580, 12'h180,
                                               12'h140, 12'h0C0, 12'h040, 12'h000};
endpackage

/* File: fsud_port.sv */
// Purpose: endpoint buffers, suspend/resume logic and pad control
// Assumes: transaction engine sits on the bus-side byte ports
// Notes: ready outputs are combinational to avoid a bubble
`timescale 1ns/100ps
module fsud_port
    import fsud_pkg::*;
#(
    parameter int SUSPEND_TICKS = FSUD_SUSPEND_TICKS,
    parameter int RESUME_TICKS = FSUD_RESUME_TICKS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic bus_side_48m_clock,
    input wire logic usb_dplus_pad_in,
    input wire logic usb_dminus_pad_in,
    output logic usb_dplus_pad_out,
    output logic usb_dminus_pad_out,
    output logic usb_dplus_pad_oe,
    output logic usb_dminus_pad_oe,
    output logic pad_pullup_en,
    output logic pad_pulldown_en,
    output logic usb_pins_owned,
    input wire logic pullup_on,
    input wire logic transceiver_disable,
    input wire logic system_io_config,
    input wire logic external_resume,
    input wire logic remote_wake_enable,
    input wire logic [15:0] ep_type,
    input wire logic [7:0] ep_is_in,
    input wire logic [7:0] ep_flip,
    output logic [7:0] ep_type_err,
    input wire logic [2:0] cpu_ep,
    input wire logic cpu_wr_valid,
    input wire logic [7:0] cpu_wr_data,
    output logic cpu_wr_ready,
    input wire logic cpu_rd_req,
    output logic [7:0] cpu_rd_data,
    output logic cpu_rd_valid,
    input wire logic [2:0] usb_ep,
    input wire logic usb_rx_valid,
    input wire logic [7:0] usb_rx_data,
    output logic usb_rx_ready,
    input wire logic usb_tx_req,
    output logic usb_tx_valid,
    output logic [7:0] usb_tx_data,
    input wire logic usb_tx_ready,
    output logic suspended,
    input wire logic irq_clear,
    output logic usb_irq
);
    typedef struct packed {
        logic [FSUD_RAM_BYTES-1:0][7:0] mem;
        logic [7:0][1:0][9:0] wp;
        logic [7:0][1:0][9:0] rp;
        logic [7:0] bank;
        logic [7:0] type_err;
        logic [7:0] rd_data;
        logic rd_valid;
        logic [1:0][7:0] buf_data;
        logic [1:0] buf_cnt;
        logic tx_valid;
        logic ck_s1, ck_s2, ck_s3;
        logic dp_s1, dp_s2, dm_s1, dm_s2, wk_s1, wk_s2, wk_s3;
        logic [1:0] div;
        logic [15:0] idle_cnt;
        logic [15:0] res_cnt;
        logic [1:0] echo;
        logic susp;
        logic irq;
        logic pu, pd, oe, own;
    } fsud_state_t;

    fsud_state_t s_q, s_d;

    function automatic logic is_dual(input logic [2:0] e);
        is_dual = FSUD_DUAL_MASK[e];
    endfunction

    function automatic logic [9:0] bank_size(input logic [2:0] e);
        bank_size = FSUD_LARGE_MASK[e] ? 10'(FSUD_LARGE_BANK) : 10'(FSUD_SMALL_BANK);
    endfunction

    // On dual-bank endpoints the CPU side owns one bank, the bus side the other; single banks are shared
    function automatic logic side_bank(input logic [2:0] e, input logic b, input logic usb);
        side_bank = is_dual(e) & (b ^ usb);
    endfunction

    function automatic logic [11:0] ram_idx(input logic [2:0] e, input logic b, input logic [9:0] p);
        ram_idx = FSUD_EP_BASE[e] + (b ? {2'h0, bank_size(e)} : 12'h000) + {2'h0, p};
    endfunction

    logic cb, ub;
    logic cpu_full, cpu_empty, usb_full, usb_empty, tick, pop, push;
    assign cb = side_bank(cpu_ep, s_q.bank[cpu_ep], 1'b0);
    assign ub = side_bank(usb_ep, s_q.bank[usb_ep], 1'b1);
    assign cpu_full = s_q.wp[cpu_ep][cb] == bank_size(cpu_ep);
    assign cpu_empty = s_q.rp[cpu_ep][cb] == s_q.wp[cpu_ep][cb];
    assign usb_full = s_q.wp[usb_ep][ub] == bank_size(usb_ep);
    assign usb_empty = s_q.rp[usb_ep][ub] == s_q.wp[usb_ep][ub];
    assign tick = s_q.ck_s2 & ~s_q.ck_s3 & (s_q.div == FSUD_TICK_DIV_LAST);
    assign pop = s_q.tx_valid & usb_tx_ready;
    // Full buffer stalls the RAM read, so a stalled receiver loses nothing
    assign push = usb_tx_req & ~usb_empty & (s_q.buf_cnt != FSUD_BUF_DEPTH);
    assign cpu_wr_ready = ~cpu_full;
    assign usb_rx_ready = ~usb_full;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [1:0] cnt;
        logic fill_usb;
        cnt = 2'h0;
        fill_usb = 1'b0;
        s_d = s_q;
        // Pins and the bus clock are asynchronous: two flops first
        s_d.ck_s1 = bus_side_48m_clock;
        s_d.ck_s2 = s_q.ck_s1;
        s_d.ck_s3 = s_q.ck_s2;
        s_d.dp_s1 = usb_dplus_pad_in;
        s_d.dp_s2 = s_q.dp_s1;
        s_d.dm_s1 = usb_dminus_pad_in;
        s_d.dm_s2 = s_q.dm_s1;
        s_d.wk_s1 = external_resume;
        s_d.wk_s2 = s_q.wk_s1;
        s_d.wk_s3 = s_q.wk_s2;
        if (s_q.ck_s2 & ~s_q.ck_s3) begin
            s_d.div = s_q.div + 2'h1;
        end
        // Illegal type for the endpoint is flagged
        for (int e = 0; e < FSUD_NUM_EP; e++) begin
            s_d.type_err[e] = is_dual(3'(e)) ? (ep_type[2*e+:2] == FSUD_CONTROL)
                                             : (ep_type[2*e+:2] == FSUD_ISO);
        end
        // CPU byte access, one 8-bit value per access
        s_d.rd_valid = 1'b0;
        if (cpu_wr_valid && !cpu_full) begin
            s_d.mem[ram_idx(cpu_ep, cb, s_q.wp[cpu_ep][cb])] = cpu_wr_data;
            s_d.wp[cpu_ep][cb] = s_q.wp[cpu_ep][cb] + 10'h001;
        end
        if (cpu_rd_req) begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data = cpu_empty ? 8'h00 : s_q.mem[ram_idx(cpu_ep, cb, s_q.rp[cpu_ep][cb])];
            if (!cpu_empty) begin
                s_d.rp[cpu_ep][cb] = s_q.rp[cpu_ep][cb] + 10'h001;
            end
        end
        if (usb_rx_valid && !usb_full) begin
            s_d.mem[ram_idx(usb_ep, ub, s_q.wp[usb_ep][ub])] = usb_rx_data;
            s_d.wp[usb_ep][ub] = s_q.wp[usb_ep][ub] + 10'h001;
        end
        // Two-entry transmit buffer
        cnt = s_q.buf_cnt;
        if (pop) begin
            s_d.buf_data[0] = s_q.buf_data[1];
            cnt = cnt - 2'h1;
        end
        if (push) begin
            s_d.buf_data[cnt[0]] = s_q.mem[ram_idx(usb_ep, ub, s_q.rp[usb_ep][ub])];
            s_d.rp[usb_ep][ub] = s_q.rp[usb_ep][ub] + 10'h001;
            cnt = cnt + 2'h1;
        end
        s_d.buf_cnt = cnt;
        s_d.tx_valid = cnt != 2'h0;
        // Hand-over: filler gets an empty bank, drainer restarts reading
        for (int e = 0; e < FSUD_NUM_EP; e++) begin
            if (ep_flip[e]) begin
                fill_usb = ~ep_is_in[e];
                if (is_dual(3'(e))) begin
                    s_d.bank[e] = ~s_q.bank[e];
                    s_d.wp[e][s_q.bank[e] ^ ~fill_usb] = 10'h000;
                    s_d.rp[e][s_q.bank[e] ^ ~fill_usb] = 10'h000;
                    s_d.rp[e][s_q.bank[e] ^ fill_usb] = 10'h000;
                end else begin
                    s_d.wp[e][0] = 10'h000;
                    s_d.rp[e][0] = 10'h000;
                end
            end
        end
        // Suspend after idle J, resume on any other line state
        if (tick) begin
            if (s_q.dp_s2 && !s_q.dm_s2) begin
                if (s_q.idle_cnt != 16'(SUSPEND_TICKS)) begin
                    s_d.idle_cnt = s_q.idle_cnt + 16'h0001;
                end
            end else begin
                s_d.idle_cnt = 16'h0000;
            end
            if (s_q.res_cnt != 16'h0000) begin
                s_d.res_cnt = s_q.res_cnt - 16'h0001;
            end
        end
        // Own K drive echoes through the pad flops; hold off resume detection
        if (s_q.oe) begin
            s_d.echo = 2'h3;
        end else if (s_q.echo != 2'h0) begin
            s_d.echo = s_q.echo - 2'h1;
        end
        if (irq_clear) begin
            s_d.irq = 1'b0;
        end
        if (!s_q.susp && s_q.idle_cnt == 16'(SUSPEND_TICKS)) begin
            s_d.susp = 1'b1;
            s_d.irq = 1'b1;
        end
        if (s_q.susp && s_q.res_cnt == 16'h0000 && s_q.echo == 2'h0 && !(s_q.dp_s2 && !s_q.dm_s2)) begin
            s_d.susp = 1'b0;
            s_d.idle_cnt = 16'h0000;
            s_d.irq = 1'b1;
        end
        // Remote wake only if the host allowed it at enumeration
        if (s_q.susp && remote_wake_enable && s_q.wk_s2 && !s_q.wk_s3 && s_q.res_cnt == 16'h0000) begin
            s_d.res_cnt = 16'(RESUME_TICKS);
        end
        // Pad control; GPIO mode releases everything
        s_d.own = ~system_io_config;
        s_d.pu = pullup_on & ~system_io_config;
        s_d.pd = transceiver_disable & ~system_io_config;
        s_d.oe = (s_d.res_cnt != 16'h0000) & ~transceiver_disable & ~system_io_config;
        if (sys_rst) begin
            s_d = '0;
            s_d.bank = FSUD_BANK_RST;
            s_d.own = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Resume signalling drives K: D+ low, D- high
    assign usb_dplus_pad_out = 1'b0;
    assign usb_dminus_pad_out = s_q.oe;
    assign usb_dplus_pad_oe = s_q.oe;
    assign usb_dminus_pad_oe = s_q.oe;
    assign pad_pullup_en = s_q.pu;
    assign pad_pulldown_en = s_q.pd;
    assign usb_pins_owned = s_q.own;
    assign ep_type_err = s_q.type_err;
    assign cpu_rd_data = s_q.rd_data;
    assign cpu_rd_valid = s_q.rd_valid;
    assign usb_tx_valid = s_q.tx_valid;
    assign usb_tx_data = s_q.buf_data[0];
    assign suspended = s_q.susp;
    assign usb_irq = s_q.irq;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb_clk @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_irq_on_suspend: assert property ($rose(s_q.susp) |-> s_q.irq)
        else $error("suspend entry without interrupt");
    a_irq_on_resume: assert property ($fell(s_q.susp) |-> s_q.irq)
        else $error("resume without interrupt");
    a_irq_sticky_line: assert property (s_q.irq && !irq_clear |=> s_q.irq)
        else $error("interrupt dropped without clear");
    a_pulldown_when_off: assert property (transceiver_disable && !system_io_config |=> s_q.pd && !s_q.oe)
        else $error("pull-down missing while transceiver off");
    a_gpio_release_pads: assert property (system_io_config |=> !s_q.oe && !s_q.pu && !s_q.own)
        else $error("pads still held in GPIO mode");
    a_wake_needs_suspend: assert property ($rose(s_q.oe) |-> $past(s_q.susp, 2) && $past(remote_wake_enable, 2))
        else $error("remote wake outside allowed suspend");
    a_no_self_resume: assert property ($fell(s_q.oe) |-> s_q.susp [*3])
        else $error("own resume drive taken as host resume");
    a_cpu_read_latency: assert property (cpu_rd_req |=> s_q.rd_valid ##1 !$past(cpu_rd_req) |-> !s_q.rd_valid)
        else $error("read answer not one cycle later");
    a_bank_ping_pong: assert property (ep_flip[4] |=> s_q.bank[4] != $past(s_q.bank[4]))
        else $error("dual bank did not swap");
    a_single_bank_fixed: assert property (ep_flip[0] |=> s_q.bank[0] == $past(s_q.bank[0]))
        else $error("single bank endpoint swapped");
    a_ptr_within_bank: assert property (s_q.wp[cpu_ep][cb] <= bank_size(cpu_ep))
        else $error("write pointer beyond bank");
    a_type_illegal_flag: assert property (ep_type[3:2] == FSUD_CONTROL |=> s_q.type_err[1])
        else $error("control type on dual bank not flagged");
    a_pin_sync_depth: assert property (##3 s_q.dp_s2 == $past(usb_dplus_pad_in, 2))
        else $error("pad input not two flops deep");
    a_tx_buf_depth: assert property (s_q.buf_cnt <= FSUD_BUF_DEPTH && (s_q.tx_valid == (s_q.buf_cnt != 2'h0)))
        else $error("transmit buffer count wrong");

    c_suspend_seen: cover property ($rose(s_q.susp));
    c_resume_seen: cover property ($fell(s_q.susp));
    c_wake_driven: cover property ($rose(s_q.oe));
    c_buffer_full: cover property (s_q.buf_cnt == FSUD_BUF_DEPTH && !usb_tx_ready);
endmodule

/* File: fsud_host_model.sv */
// Purpose: host side of the full-speed bus for the port bench
// Assumes: pad levels resolve from the device enables and the pull-up
// Notes: stalls the byte sink only when the bench asks for it
`timescale 1ns/100ps
module fsud_host_model (
    input wire logic clk,
    output logic bus_clk,
    input wire logic dp_oe,
    input wire logic dp_out,
    input wire logic dm_oe,
    input wire logic dm_out,
    input wire logic pullup_en,
    input wire logic host_k,
    output logic dp_in,
    output logic dm_in,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    input wire logic stall
);
    logic [1:0] ph = 2'h0;
    logic [7:0] got_q[$];
    initial begin
        bus_clk = 1'b0;
        forever #10.4 bus_clk = ~bus_clk;
    end
    // Released D+ follows the pull-up, so an idle bus reads J only when it is on
    assign dp_in = dp_oe ? dp_out : (!host_k && pullup_en);
    assign dm_in = dm_oe ? dm_out : host_k;
    // Half-rate sink under stall, so the two-entry buffer must fill
    assign tx_ready = !(stall && ph[1]);
    always @(posedge clk) begin
        ph <= ph + 2'h1;
        if (tx_valid && tx_ready) begin
            got_q.push_back(tx_data);
        end
    end
endmodule

/* File: fsud_port_tb_top.sv */
// Purpose: self-checking bench of the device port
// Assumes: host model on the pads and on the bus-side transmit byte port
// Notes: short suspend and resume counts keep the run brief
`timescale 1ns/100ps
module fsud_port_tb_top;
    import fsud_pkg::*;
    logic clk, sys_rst, bclk, dp_in, dm_in, dp_out, dm_out, dp_oe, dm_oe, pu_en, pd_en, owned, host_k, stall;
    logic pullup_on, transceiver_disable, system_io_config, external_resume, remote_wake_enable, irq_clear;
    logic cpu_wr_valid, cpu_wr_ready, cpu_rd_req, cpu_rd_valid, usb_rx_valid, usb_rx_ready, suspended, usb_irq;
    logic usb_tx_req, usb_tx_valid, usb_tx_ready;
    logic [15:0] ep_type, seed;
    logic [7:0] ep_is_in, ep_flip, ep_type_err, cpu_wr_data, cpu_rd_data, usb_rx_data, usb_tx_data, bk, exp;
    logic [2:0] cpu_ep, usb_ep;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    bit ok;
    int q[16][$];
    fsud_port #(.SUSPEND_TICKS(20), .RESUME_TICKS(10)) i_fsud_port (
        .clk(clk), .sys_rst(sys_rst), .bus_side_48m_clock(bclk), .usb_dplus_pad_in(dp_in),
        .usb_dminus_pad_in(dm_in), .usb_dplus_pad_out(dp_out), .usb_dminus_pad_out(dm_out),
        .usb_dplus_pad_oe(dp_oe), .usb_dminus_pad_oe(dm_oe), .pad_pullup_en(pu_en), .pad_pulldown_en(pd_en),
        .usb_pins_owned(owned), .pullup_on(pullup_on), .transceiver_disable(transceiver_disable),
        .system_io_config(system_io_config), .external_resume(external_resume),
        .remote_wake_enable(remote_wake_enable), .ep_type(ep_type), .ep_is_in(ep_is_in), .ep_flip(ep_flip),
        .ep_type_err(ep_type_err), .cpu_ep(cpu_ep), .cpu_wr_valid(cpu_wr_valid), .cpu_wr_data(cpu_wr_data),
        .cpu_wr_ready(cpu_wr_ready), .cpu_rd_req(cpu_rd_req), .cpu_rd_data(cpu_rd_data),
        .cpu_rd_valid(cpu_rd_valid), .usb_ep(usb_ep), .usb_rx_valid(usb_rx_valid), .usb_rx_data(usb_rx_data),
        .usb_rx_ready(usb_rx_ready), .usb_tx_req(usb_tx_req), .usb_tx_valid(usb_tx_valid),
        .usb_tx_data(usb_tx_data), .usb_tx_ready(usb_tx_ready), .suspended(suspended), .irq_clear(irq_clear),
        .usb_irq(usb_irq));
    fsud_host_model i_fsud_host_model (
        .clk(clk), .bus_clk(bclk), .dp_oe(dp_oe), .dp_out(dp_out), .dm_oe(dm_oe), .dm_out(dm_out),
        .pullup_en(pu_en), .host_k(host_k), .dp_in(dp_in), .dm_in(dm_in), .tx_valid(usb_tx_valid),
        .tx_data(usb_tx_data), .tx_ready(usb_tx_ready), .stall(stall));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction
    // Bank index of the CPU side and of the bus side; single banks are shared
    function automatic int cb(input int e);
        return 2 * e + (FSUD_DUAL_MASK[e] ? bk[e] : 0);
    endfunction
    function automatic int bb(input int e);
        return 2 * e + (FSUD_DUAL_MASK[e] ? !bk[e] : 0);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        num_checks++;
        if (got !== want) begin
            n_errors++;
            $display("ERROR %0t %s got %0h expected %0h", $time, what, got, want);
        end
    endtask
    task automatic step(input int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim, output int m);
        for (m = 0; m < lim && s !== v; m++)
            step();
    endtask
    task automatic put(input bit bus, input int e, input logic [7:0] d, output bit took);
        step();
        if (bus) begin
            usb_ep = e[2:0];
            usb_rx_valid = 1'b1;
            usb_rx_data = d;
        end else begin
            cpu_ep = e[2:0];
            cpu_wr_valid = 1'b1;
            cpu_wr_data = d;
        end
        #1 took = bus ? usb_rx_ready : cpu_wr_ready;
    endtask
    // One extra byte past capacity when full is set, which must be refused
    task automatic fill(input bit bus, input int e, input int cnt, input bit full);
        int k;
        logic [7:0] b;
        k = bus ? bb(e) : cb(e);
        for (int i = 0; i < cnt + full; i++) begin
            b = rnd();
            put(bus, e, b, ok);
            chk(ok, i < cnt, "accept");
            if (i < cnt) begin
                q[k].push_back(b);
            end
        end
        step();
        cpu_wr_valid = 1'b0;
        usb_rx_valid = 1'b0;
    endtask
    task automatic get(input int e);
        step();
        cpu_ep = e[2:0];
        cpu_rd_req = 1'b1;
        step();
        cpu_rd_req = 1'b0;
        chk(cpu_rd_valid, 1, "read valid");
        chk(cpu_rd_data, q[cb(e)].size() ? q[cb(e)].pop_front() : 0, "read data");
    endtask
    task automatic flip(input int e);
        step();
        ep_flip[e] = 1'b1;
        step();
        ep_flip[e] = 1'b0;
        if (FSUD_DUAL_MASK[e]) begin
            bk[e] = !bk[e];
            q[ep_is_in[e] ? cb(e) : bb(e)].delete();
        end else begin
            q[2 * e].delete();
        end
    endtask
    task automatic drain(input int e);
        int k;
        k = bb(e);
        i_fsud_host_model.got_q.delete();
        step();
        usb_ep = e[2:0];
        usb_tx_req = 1'b1;
        for (n = 0; n < 4 * q[k].size() + 20 && i_fsud_host_model.got_q.size() < q[k].size(); n++)
            step();
        usb_tx_req = 1'b0;
        chk(i_fsud_host_model.got_q.size(), q[k].size(), "tx count");
        while (i_fsud_host_model.got_q.size() > 0)
            chk(i_fsud_host_model.got_q.pop_front(), q[k].pop_front(), "tx data");
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {sys_rst, host_k, stall, pullup_on, transceiver_disable, system_io_config, external_resume} = 7'h40;
        {remote_wake_enable, irq_clear, cpu_wr_valid, cpu_rd_req, usb_rx_valid, usb_tx_req} = 6'h00;
        {cpu_ep, usb_ep, cpu_wr_data, usb_rx_data, ep_flip, bk} = '0;
        ep_type = 16'h5555;
        ep_is_in = 8'h13;
        seed = 16'h64C5;
        // Clock runs with reset held for six cycles before any access
        repeat (6) @(posedge clk);
        #1 sys_rst = 1'b0;
        chk({pu_en, pd_en, owned, suspended, usb_irq, dp_oe, dm_oe, usb_tx_valid}, 8'h20, "reset");
        for (int i = 0; i < 8; i++) begin
            {pullup_on, transceiver_disable, system_io_config} = i[2:0];
            step(2);
            chk({pu_en, pd_en, owned}, {i[2] & !i[0], i[1] & !i[0], !i[0]}, "pads");
        end
        {pullup_on, transceiver_disable, system_io_config} = 3'h0;
        for (int i = 0; i < 12; i++) begin
            ep_type = (i < 4) ? {8{i[1:0]}} : {rnd(), rnd()};
            for (int e = 0; e < 8; e++)
                exp[e] = (ep_type[2*e +: 2] == FSUD_CONTROL) ? FSUD_DUAL_MASK[e] :
                    (ep_type[2*e +: 2] == FSUD_ISO) && !FSUD_DUAL_MASK[e];
            step(2);
            chk(ep_type_err, exp, "type check");
        end
        // Bulk on every endpoint; iso would be legal only on dual banks
        ep_type = 16'h5555;
        fill(0, 0, 64, 1);
        repeat (65) get(0);
        flip(0);
        fill(0, 0, 3, 0);
        repeat (3) get(0);
        fill(0, 1, 64, 1);
        flip(1);
        stall = 1'b1;
        // Bus drains one bank while the CPU fills the other
        fork
            drain(1);
            fill(0, 1, 20, 0);
        join
        flip(1);
        drain(1);
        fill(0, 4, 512, 1);
        flip(4);
        drain(4);
        fill(1, 2, 64, 1);
        flip(2);
        repeat (65) get(2);
        {pullup_on, remote_wake_enable} = 2'h3;
        wait_for(suspended, 1'b1, 500, n);
        chk({n >= 300 && n <= 400, usb_irq}, 2'h3, "suspend");
        irq_clear = 1'b1;
        step();
        irq_clear = 1'b0;
        chk(usb_irq, 0, "irq clear");
        external_resume = 1'b1;
        wait_for(dp_oe, 1'b1, 20, n);
        chk({n < 20, dm_oe, dp_out, dm_out}, 4'hD, "wake drive");
        step(100);
        chk({dp_oe, suspended}, 2'h3, "wake hold");
        wait_for(dp_oe, 1'b0, 200, n);
        chk(n > 40 && n < 100, 1, "wake length");
        // Idle J after the drive must not look like a host resume
        step(4);
        chk(suspended, 1, "no self resume");
        host_k = 1'b1;
        wait_for(suspended, 1'b0, 40, n);
        chk({n < 40, usb_irq}, 2'h3, "resume");
        // Disconnect order: transceiver off first, then pull-up removed
        transceiver_disable = 1'b1;
        step(2);
        chk({pd_en, pu_en, dp_oe}, 3'h6, "disconnect pull-down");
        pullup_on = 1'b0;
        step(2);
        chk({pd_en, pu_en, owned}, 3'h5, "disconnect pull-up off");
        test_done();
    end
endmodule
